// >>> core/rbx_pkg.sv
// package for the registered bus exchanger: widths and reset values
// assumes one clock, synchronous active-low reset, no software registers
`default_nettype none

package rbx_pkg;
    // ******************************************************
    // widths
    // ******************************************************
    localparam int THIN_W = 16;  // narrow port, one wide half each
    localparam int MASK_W = 2;   // one mask bit per data byte

    // ******************************************************
    // reset values
    // ******************************************************
    localparam logic [THIN_W-1:0] DATA_RST = 16'h0000;
    localparam logic [MASK_W-1:0] MASK_RST = 2'h0;
    localparam logic              DIR_RST  = 1'h0;  // narrow side faces out
    localparam logic              OE_RST   = 1'h0;  // all pins floating

    // ******************************************************
    // pipeline depths seen at the pins, in clock edges
    // ******************************************************
    localparam int LOW_DEPTH  = 2;
    localparam int HIGH_DEPTH = 1;
endpackage

`default_nettype wire

// >>> core/rbx_stage.sv
// one storage register with a load enable and synchronous reset
// assumes the caller decides when it loads; rising edge only
`default_nettype none

module rbx_stage #(
    parameter int             W   = 16,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    // ******************************************************
    // storage
    // ******************************************************
    // hold is the default: a stage only moves when told
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q <= RST;
        end else if (load) begin
            q <= d;
        end
    end
endmodule

`default_nettype wire

// >>> core/rbx_exchanger.sv
// registered exchanger between a narrow port and a two-half wide port
// assumes inputs synchronous to sys_clk; pin resolution done outside
//
// Operation
// - all storage captures on the rising clock edge only
// - narrow word maps onto either half of the double-width port
// - wide-to-narrow: half_pick picks low or high half for thin_side
// - narrow-to-wide low half passes two register stages
// - narrow-to-wide high half passes one register stage
// - flow_sense is registered; direction changes on a clock edge
// - drive_enable_low high floats thin, both halves and mask outputs
// - flow_sense high drives wide halves; low drives thin_side
// - half_pick low captures thin_side toward both halves each edge in narrow-to-wide mode
// - half_pick high holds the wide outputs in narrow-to-wide mode
// - wide-to-narrow applies with enable low and flow_sense low
// - half_pick low loads the low half, driven onto thin_side
// - half_pick high: high half reaches thin_side after two edges
// - masks registered like narrow-to-wide data, low mask two edges
// - mask outputs enabled by drive_enable_low alone
`default_nettype none

module rbx_exchanger #(
    parameter int W = rbx_pkg::THIN_W,
    parameter int M = rbx_pkg::MASK_W
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         flow_sense,
    input  wire logic         half_pick,
    input  wire logic         drive_enable_low,
    input  wire logic [W-1:0] thin_in,
    output var  logic [W-1:0] thin_out,
    output var  logic         thin_oe,
    input  wire logic [W-1:0] wide_low_in,
    input  wire logic [W-1:0] wide_high_in,
    output var  logic [W-1:0] wide_low_out,
    output var  logic [W-1:0] wide_high_out,
    output var  logic         wide_oe,
    input  wire logic         mask_in_low,
    input  wire logic         mask_in_high,
    output var  logic [M-1:0] mask_out_low,
    output var  logic [M-1:0] mask_out_high,
    output var  logic         mask_oe
);
    // ******************************************************
    // direction and enables
    // ******************************************************
    logic         dir_r;
    logic         dir_nxt;
    logic         thin_oe_nxt;
    logic         wide_oe_nxt;
    logic         mask_oe_nxt;

    // a pin group drives only while enabled and wanted; shared by all
    // three groups so the enable polarity lives in one place
    function automatic logic grp_on(
        input logic en_low,
        input logic want
    );
        return !en_low && want;
    endfunction

    assign dir_nxt     = flow_sense;
    assign wide_oe_nxt = grp_on(drive_enable_low, flow_sense);
    assign thin_oe_nxt = grp_on(drive_enable_low, !flow_sense);
    assign mask_oe_nxt = grp_on(drive_enable_low, 1'b1);

    // enables are registered with the direction so a turnaround
    // never has both ports driving between edges
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            dir_r   <= rbx_pkg::DIR_RST;
            thin_oe <= rbx_pkg::OE_RST;
            wide_oe <= rbx_pkg::OE_RST;
            mask_oe <= rbx_pkg::OE_RST;
        end else begin
            dir_r   <= dir_nxt;
            thin_oe <= thin_oe_nxt;
            wide_oe <= wide_oe_nxt;
            mask_oe <= mask_oe_nxt;
        end
    end

    // ******************************************************
    // load decode
    // ******************************************************
    logic         a2b_load;
    logic         b2a_load;
    logic         mask_load;
    logic [W-1:0] low_stage_q;
    logic [W-1:0] high_stage_q;
    logic [W-1:0] thin_d;
    logic [M-1:0] mask_in;
    logic [M-1:0] mask_stage_q;

    // the old direction governs the edge on which it changes
    assign a2b_load  = dir_r && !half_pick;
    assign b2a_load  = !dir_r;
    assign mask_load = !half_pick;
    assign mask_in   = {mask_in_high, mask_in_low};
    assign thin_d    = half_pick ? high_stage_q : wide_low_in;

    // ******************************************************
    // narrow to wide data
    // ******************************************************
    // first of the two low-half stages
    rbx_stage #(.W(W), .RST(rbx_pkg::DATA_RST)) u_low_first (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (a2b_load),
        .d       (thin_in),
        .q       (low_stage_q)
    );

    // second low-half stage drives the pins
    rbx_stage #(.W(W), .RST(rbx_pkg::DATA_RST)) u_low_out (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (a2b_load),
        .d       (low_stage_q),
        .q       (wide_low_out)
    );

    // high half has a single register
    rbx_stage #(.W(W), .RST(rbx_pkg::DATA_RST)) u_high_out (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (a2b_load),
        .d       (thin_in),
        .q       (wide_high_out)
    );

    // ******************************************************
    // wide to narrow data
    // ******************************************************
    // high half waits here one edge before reaching the output
    rbx_stage #(.W(W), .RST(rbx_pkg::DATA_RST)) u_high_first (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (b2a_load),
        .d       (wide_high_in),
        .q       (high_stage_q)
    );

    // narrow output register, low half lands in one edge
    rbx_stage #(.W(W), .RST(rbx_pkg::DATA_RST)) u_thin_out (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (b2a_load),
        .d       (thin_d),
        .q       (thin_out)
    );

    // ******************************************************
    // mask path, independent of direction
    // ******************************************************
    rbx_stage #(.W(M), .RST(rbx_pkg::MASK_RST)) u_mask_first (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (mask_load),
        .d       (mask_in),
        .q       (mask_stage_q)
    );

    rbx_stage #(.W(M), .RST(rbx_pkg::MASK_RST)) u_mask_low (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (mask_load),
        .d       (mask_stage_q),
        .q       (mask_out_low)
    );

    rbx_stage #(.W(M), .RST(rbx_pkg::MASK_RST)) u_mask_high (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (mask_load),
        .d       (mask_in),
        .q       (mask_out_high)
    );

    // ******************************************************
    // checks
    // ******************************************************
    // contents are only trusted after a full flush; reset does it here
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // low half appears two loading edges after capture
    chk_low_two_edges: assert property (
        (dir_r && !half_pick) ##1 (dir_r && !half_pick)
        |=> wide_low_out == $past(thin_in, rbx_pkg::LOW_DEPTH))
        else $error("wide low half not two edges behind thin side");

    // high half appears one edge after capture
    chk_high_one_edge: assert property (
        (dir_r && !half_pick)
        |=> wide_high_out == $past(thin_in, rbx_pkg::HIGH_DEPTH))
        else $error("wide high half not one edge behind thin side");

    // selection high freezes the wide outputs
    chk_wide_hold: assert property (
        (dir_r && half_pick) |=> $stable(wide_low_out)
            && $stable(wide_high_out))
        else $error("wide outputs moved while held");

    // direction only changes one edge after the pin
    chk_dir_reg: assert property (
        $changed(flow_sense) |=> dir_r == $past(flow_sense)
            && $past(dir_r) != dir_r)
        else $error("direction not registered on the edge");

    // disable floats every output group
    chk_all_float: assert property (
        drive_enable_low |=> !thin_oe && !wide_oe && !mask_oe)
        else $error("output driven while disabled");

    // exactly one data port drives when enabled
    chk_one_driver: assert property (
        !drive_enable_low |=> (thin_oe != wide_oe)
            && wide_oe == $past(flow_sense))
        else $error("data port enables wrong for direction");

    // mask enable ignores direction
    chk_mask_oe: assert property (
        !drive_enable_low ##1 $changed(flow_sense) && !drive_enable_low
        |=> mask_oe)
        else $error("mask enable followed direction");

    // low half reaches the narrow port in one edge
    chk_thin_low: assert property (
        (!dir_r && !half_pick) |=> thin_out == $past(wide_low_in))
        else $error("thin side not loaded from low half");

    // high half reaches the narrow port in two edges
    chk_thin_high: assert property (
        !dir_r ##1 (!dir_r && half_pick)
        |=> thin_out == $past(wide_high_in, 2))
        else $error("thin side not loaded from high half");

    // low mask two edges, high mask one edge
    chk_mask_pipe: assert property (
        !half_pick ##1 !half_pick
        |=> mask_out_low == $past(mask_in, 2)
            && mask_out_high == $past(mask_in))
        else $error("mask outputs out of step");

    // masks hold while selection is high
    chk_mask_hold: assert property (
        half_pick |=> $stable(mask_out_low) && $stable(mask_out_high))
        else $error("mask outputs moved while held");

    // ******************************************************
    // reset, direction and stage checks
    // ******************************************************
    // reset leaves every pin group floating and the data cleared
    chk_reset_clear: assert property (
        $rose(rstn) |-> !thin_oe && !wide_oe && !mask_oe
            && wide_low_out == rbx_pkg::DATA_RST
            && wide_high_out == rbx_pkg::DATA_RST
            && thin_out == rbx_pkg::DATA_RST
            && mask_out_low == rbx_pkg::MASK_RST)
        else $error("outputs not cleared by reset");

    // wide side frozen while the registered direction faces inward
    chk_wide_dir_hold: assert property (
        (rstn && !dir_r) |=> $stable(wide_low_out) && $stable(wide_high_out))
        else $error("wide outputs moved in wide-to-narrow mode");

    // narrow output only moves while facing outward
    chk_thin_dir_hold: assert property (
        (rstn && dir_r) |=> $stable(thin_out))
        else $error("thin side moved in narrow-to-wide mode");

    // first low-half stage takes the narrow word on a loading edge
    chk_low_first: assert property (
        (rstn && dir_r && !half_pick) |=> low_stage_q == $past(thin_in))
        else $error("first low stage missed the narrow word");

    // high-half holding register follows the wide pins each loading edge
    chk_high_first: assert property (
        (rstn && !dir_r) |=> high_stage_q == $past(wide_high_in))
        else $error("high half not held for the second edge");

    // direction register follows the pin one edge late
    chk_dir_follow: assert property (
        rstn |=> dir_r == $past(flow_sense))
        else $error("direction register lost the pin level");

    // mask group drives whenever enabled, either direction
    chk_mask_drive: assert property (
        (rstn && !drive_enable_low) |=> mask_oe)
        else $error("mask outputs floated while enabled");

    // wide-to-narrow: only the narrow port drives
    chk_thin_drive: assert property (
        (rstn && !drive_enable_low && !flow_sense) |=> thin_oe && !wide_oe)
        else $error("narrow port not sole driver");

    // first mask stage takes both mask pins on a loading edge
    chk_mask_first: assert property (
        (rstn && !half_pick) |=> mask_stage_q == $past(mask_in))
        else $error("first mask stage missed the mask pins");
endmodule

`default_nettype wire

// >>> verification/rbx_far_model.sv
// far-side model of the wide bus: drives both halves while floated
// assumes the exchanger's wide_oe is high while it drives the halves
`default_nettype none

module rbx_far_model (
    input  wire logic        wide_oe,
    input  wire logic [15:0] wide_low_out,
    input  wire logic [15:0] wide_high_out,
    input  wire logic [15:0] low_val,
    input  wire logic [15:0] high_val,
    output wire logic [15:0] wide_low_in,
    output wire logic [15:0] wide_high_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************
    // wire resolution
    // ************************************************
    // far side only drives once the registered wide_oe has let go,
    // so the two drivers never fight on the halves
    assign wide_low_in  = wide_oe ? wide_low_out : low_val;
    assign wide_high_in = wide_oe ? wide_high_out : high_val;
endmodule

`default_nettype wire

// >>> verification/rbx_exchanger_tb.sv
// self-checking bench for the registered bus exchanger
// assumes rbx_pkg, rbx_exchanger and rbx_far_model are compiled first
`default_nettype none

module rbx_exchanger_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************
    // stimulus and wiring
    // ************************************************
    logic        sys_clk    = 1'b0;
    logic        rstn       = 1'b0;
    logic        flow_sense = 1'b0;
    logic        half_pick  = 1'b0;
    logic        den        = 1'b1;
    logic        m_lo       = 1'b0;
    logic        m_hi       = 1'b0;
    logic [15:0] thin_in    = 16'h0000;
    logic [15:0] low_val    = 16'h0000;
    logic [15:0] high_val   = 16'h0000;
    wire  logic [15:0] thin_out, wl_in, wh_in, wl_out, wh_out;
    wire  logic [1:0]  mo_lo, mo_hi;
    wire  logic        thin_oe, wide_oe, mask_oe;
    int          err_total  = 0;
    int          num_checks = 0;

    always #50 sys_clk = ~sys_clk;

    rbx_exchanger #(.W(16), .M(2)) rbx_exchanger_i (
        .sys_clk(sys_clk), .rstn(rstn), .flow_sense(flow_sense),
        .half_pick(half_pick), .drive_enable_low(den), .thin_in(thin_in),
        .thin_out(thin_out), .thin_oe(thin_oe), .wide_low_in(wl_in),
        .wide_high_in(wh_in), .wide_low_out(wl_out),
        .wide_high_out(wh_out), .wide_oe(wide_oe), .mask_in_low(m_lo),
        .mask_in_high(m_hi), .mask_out_low(mo_lo), .mask_out_high(mo_hi),
        .mask_oe(mask_oe));

    rbx_far_model rbx_far_model_i (
        .wide_oe(wide_oe), .wide_low_out(wl_out), .wide_high_out(wh_out),
        .low_val(low_val), .high_val(high_val), .wide_low_in(wl_in),
        .wide_high_in(wh_in));

    // ************************************************
    // compare and report
    // ************************************************
    task automatic chk_data(string nm, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic chk_flag(string nm, logic exp, logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %b got %b", nm, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    // reset released after the second edge; outputs must come up floating
    task automatic t_reset();
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        chk_flag("thin_oe", 1'b0, thin_oe);
        chk_flag("wide_oe", 1'b0, wide_oe);
        chk_data("wide_low", 16'h0000, wl_out);
        chk_flag("mask_oe", 1'b0, mask_oe);
        chk_data("thin_out", 16'h0000, thin_out);
    endtask

    // every enable/direction pair, {den, flow_sense}
    task automatic t_enables();
        logic [1:0] cfg [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            {den, flow_sense} <= cfg[i];
            @(posedge sys_clk);
            #1;
            chk_flag("wide_oe", !cfg[i][1] && cfg[i][0], wide_oe);
            chk_flag("thin_oe", !cfg[i][1] && !cfg[i][0], thin_oe);
            chk_flag("mask_oe", !cfg[i][1], mask_oe);
        end
    endtask

    // back-to-back words, then a hold with busy inputs
    task automatic t_narrow_to_wide();
        @(posedge sys_clk);
        flow_sense <= 1'b1;
        thin_in <= 16'ha5c3;
        m_lo <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk_data("wide_high", 16'h0000, wh_out);
        @(posedge sys_clk);
        thin_in <= 16'h3c5a;
        m_lo <= 1'b0;
        m_hi <= 1'b1;
        #1;
        chk_data("wide_high", 16'ha5c3, wh_out);
        chk_data("wide_low", 16'h0000, wl_out);
        @(posedge sys_clk);
        half_pick <= 1'b1;
        thin_in <= 16'hffff;
        m_lo <= 1'b1;
        #1;
        chk_data("wide_low", 16'ha5c3, wl_out);
        chk_data("wide_high", 16'h3c5a, wh_out);
        chk_data("mask_high", 16'h0002, {14'h0000, mo_hi});
        chk_data("mask_low", 16'h0001, {14'h0000, mo_lo});
        repeat (2) @(posedge sys_clk);
        #1;
        chk_data("wide_low", 16'ha5c3, wl_out);
        chk_data("wide_high", 16'h3c5a, wh_out);
        chk_data("mask_high", 16'h0002, {14'h0000, mo_hi});
    endtask

    // low half straight through, high half via the second register
    task automatic t_wide_to_narrow();
        @(posedge sys_clk);
        flow_sense <= 1'b0;
        half_pick <= 1'b0;
        low_val <= 16'h1234;
        high_val <= 16'h9abc;
        repeat (2) @(posedge sys_clk);
        half_pick <= 1'b1;
        high_val <= 16'h0ff0;
        #1;
        chk_flag("thin_oe", 1'b1, thin_oe);
        chk_flag("wide_oe", 1'b0, wide_oe);
        chk_data("thin_out", 16'h1234, thin_out);
        @(posedge sys_clk);
        #1;
        chk_data("thin_out", 16'h9abc, thin_out);
    endtask

    // ************************************************
    // main sequence and hang guard
    // ************************************************
    initial begin
        t_reset();
        t_enables();
        t_narrow_to_wide();
        t_wide_to_narrow();
        results();
    end

    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule

`default_nettype wire
